// >>> dlp_ctrl_end.sv
`timescale 1ns/100ps
`include "dlp_consts.svh"
module dlp_ctrl_end #(
  parameter int REFI_CYC = `DLP_REFI_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  dlp_if.ctrl link,
  input wire logic req_self_refresh,
  input wire logic req_powerdown,
  input wire logic req_wake,
  input wire logic slow_exit_sel,
  input wire logic banks_idle,
  input wire logic burst_busy,
  output logic low_power,
  output logic ready,
  output logic read_ready
);
  import dlp_pkg::*;
  typedef struct packed {
    dlp_state_e st;
    logic cke;
    logic odt;
    logic sref;
    dlp_cnt_t pulse;
    dlp_cnt_t wait_cnt;
    dlp_cnt_t read_cnt;
    logic [31:0] stay;
  } dlp_ctrl_s;
  dlp_ctrl_s s_reg;
  dlp_ctrl_s s_next;
  logic pulse_ok;
  assign pulse_ok = (s_reg.pulse >= 16'(`DLP_MIN_CKE_PULSE_CYC)); // see (RULE_24)
  always_comb
  begin
    s_next = s_reg;
    s_next.sref = 1'b0;
    if (s_reg.pulse != 16'hFFFF)
      s_next.pulse = s_reg.pulse + 16'h0001;
    if (s_reg.wait_cnt != '0)
      s_next.wait_cnt = s_reg.wait_cnt - 16'h0001;
    if (s_reg.read_cnt != '0)
      s_next.read_cnt = s_reg.read_cnt - 16'h0001;
    case (s_reg.st)
      DLP_ST_RUN:
      begin
        // Termination never driven on, so clock changes stay legal
        s_next.odt = 1'b0; // see (RULE_02) see (RULE_22)
        // Busy bursts and mode writes block CKE drop
        if (pulse_ok && s_reg.wait_cnt == '0 && !burst_busy) // see (RULE_10) see (RULE_17) see (RULE_18) see (RULE_19) see (RULE_20)
        begin
          if (req_self_refresh && banks_idle) // see (RULE_05)
          begin
            s_next.st = DLP_ST_SREF;
            s_next.sref = 1'b1; // see (RULE_01)
            s_next.cke = 1'b0;
            s_next.pulse = '0;
          end
          else if (req_powerdown)
          begin
            // Loop taken as locked whenever running normally
            s_next.st = banks_idle ? DLP_ST_PPD : DLP_ST_APD; // see (RULE_09) see (RULE_14)
            s_next.cke = 1'b0;
            s_next.pulse = '0;
            s_next.stay = '0;
          end
        end
      end
      DLP_ST_SREF:
      begin
        // Clock assumed stable again before wake
        if (req_wake && pulse_ok) // see (RULE_04)
        begin
          s_next.st = DLP_ST_SREF_EXIT;
          s_next.cke = 1'b1;
          s_next.pulse = '0;
          s_next.wait_cnt = 16'(`DLP_SR_EXIT_NONREAD_CYC); // see (RULE_06)
          s_next.read_cnt = 16'(`DLP_SR_EXIT_READ_CYC); // see (RULE_07)
        end
      end
      DLP_ST_PPD, DLP_ST_APD:
      begin
        s_next.stay = s_reg.stay + 32'h00000001;
        // Refresh debt forces wake before nine intervals
        if (pulse_ok && (req_wake || s_reg.stay >= 32'(`DLP_MAX_PD_REFI * REFI_CYC) - 32'h00000010)) // see (RULE_15)
        begin
          s_next.st = DLP_ST_PD_EXIT;
          s_next.cke = 1'b1;
          s_next.pulse = '0;
          if (s_reg.st == DLP_ST_PPD)
            s_next.wait_cnt = 16'(`DLP_PRECHARGE_PD_EXIT_CYC); // see (RULE_16)
          else if (slow_exit_sel)
            s_next.wait_cnt = 16'(`DLP_SLOW_ACTIVE_EXIT_CYC);
          else
            s_next.wait_cnt = 16'(`DLP_FAST_ACTIVE_EXIT_CYC);
        end
      end
      DLP_ST_SREF_EXIT, DLP_ST_PD_EXIT:
      begin
        if (s_reg.wait_cnt <= 16'h0001)
          s_next.st = DLP_ST_RUN; // see (RULE_08)
      end
      default: s_next.st = DLP_ST_RUN;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg.st <= DLP_ST_RUN;
      s_reg.cke <= 1'b1;
      s_reg.odt <= 1'b0;
      s_reg.sref <= 1'b0;
      s_reg.pulse <= '0;
      s_reg.wait_cnt <= '0;
      s_reg.read_cnt <= '0;
      s_reg.stay <= '0;
    end
    else
      s_reg <= s_next;
  end
  // Only NOP is ever driven besides the self-refresh entry
  assign link.cke = s_reg.cke; // see (RULE_03)
  assign link.cs_n = 1'b0;
  assign link.ras_n = !s_reg.sref;
  assign link.cas_n = !s_reg.sref;
  assign link.we_n = 1'b1; // see (RULE_08)
  assign link.odt = s_reg.odt;
  assign link.a12 = slow_exit_sel;
  assign low_power = (s_reg.st != DLP_ST_RUN);
  assign ready = (s_reg.st == DLP_ST_RUN) && (s_reg.wait_cnt == '0);
  assign read_ready = ready && (s_reg.read_cnt == '0);
endmodule // dlp_ctrl_end

// >>> dlp_consts.svh
// Behaviour
// (RULE_01) CS RAS CAS CKE low, WE high: self-refresh
// (RULE_02) Controller turns termination off before self-refresh
// (RULE_03) CKE held low keeps self-refresh; inputs ignored
// (RULE_04) Clock may change after entry, restart before exit
// (RULE_05) Self-refresh only with all banks idle
// (RULE_06) Non-read commands wait refresh cycle plus 10ns
// (RULE_07) Reads wait 200 clocks after self-refresh exit
// (RULE_08) Exit interval: CKE high, NOP or deselect
// (RULE_09) CKE low with NOP/deselect enters power-down
// (RULE_10) No CKE drop during mode write or burst
// (RULE_11) Open row means active; A12 picks exit speed
// (RULE_12) Loop off except fast-exit active power-down
// (RULE_13) Power-down gates buffers except clock, termination, CKE
// (RULE_14) Enter power-down locked, else reset loop
// (RULE_15) Power-down stay at most nine refresh intervals
// (RULE_16) CKE high with NOP exits; wait exit latency
// (RULE_17) After read wait read latency plus half burst
// (RULE_18) After write wait WL, half burst, turnaround
// (RULE_19) After write auto-precharge wait internal precharge
// (RULE_20) Power-down after refresh or mode write delay
// (RULE_21) NOP and deselect register nothing new
// (RULE_22) Frequency change only in precharge power-down
// (RULE_23) Unexpected CKE drop needs full re-initialisation
// (RULE_24) CKE phases last at least three clocks
`ifndef DLP_CONSTS_SVH
`define DLP_CONSTS_SVH
`define DLP_CLK_PERIOD_NS 10
`define DLP_REFRESH_CYCLE_TIME_NS 128
`define DLP_SR_EXIT_EXTRA_NS 10
`define DLP_SR_EXIT_NONREAD_CYC (((`DLP_REFRESH_CYCLE_TIME_NS + `DLP_SR_EXIT_EXTRA_NS) + `DLP_CLK_PERIOD_NS - 1) / `DLP_CLK_PERIOD_NS)
`define DLP_SR_EXIT_READ_CYC 200
`define DLP_PRECHARGE_PD_EXIT_CYC 2
`define DLP_FAST_ACTIVE_EXIT_CYC 2
`define DLP_SLOW_ACTIVE_EXIT_CYC 8
`define DLP_MIN_CKE_PULSE_CYC 3
`define DLP_REFI_NS 7800
`define DLP_REFI_CYC (`DLP_REFI_NS / `DLP_CLK_PERIOD_NS)
`define DLP_MAX_PD_REFI 9
`define DLP_CNT_W 16
`endif

// >>> dlp_pkg.sv
package dlp_pkg;
  typedef enum logic [3:0] {
    DLP_CMD_NOP = 4'h0,
    DLP_CMD_DESEL = 4'h1,
    DLP_CMD_SREF = 4'h2,
    DLP_CMD_AREF = 4'h3,
    DLP_CMD_ACT = 4'h4,
    DLP_CMD_PRE = 4'h5,
    DLP_CMD_READ = 4'h6,
    DLP_CMD_WRITE = 4'h7,
    DLP_CMD_MRS = 4'h8
  } dlp_cmd_e;
  typedef enum logic [5:0] {
    DLP_ST_RUN = 6'h01,
    DLP_ST_SREF = 6'h02,
    DLP_ST_SREF_EXIT = 6'h04,
    DLP_ST_PPD = 6'h08,
    DLP_ST_APD = 6'h10,
    DLP_ST_PD_EXIT = 6'h20
  } dlp_state_e;
  typedef logic [15:0] dlp_cnt_t;
endpackage

// >>> dlp_if.sv
`timescale 1ns/100ps
interface dlp_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic a12;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output odt, output a12);
  modport dram (input cke, input cs_n, input ras_n, input cas_n, input we_n, input odt, input a12);
endinterface

// >>> dlp_cmd_decode.sv
`timescale 1ns/100ps
`include "dlp_consts.svh"
module dlp_cmd_decode (
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  output dlp_pkg::dlp_cmd_e cmd
);
  import dlp_pkg::*;
  always_comb
  begin
    if (cs_n)
      cmd = DLP_CMD_DESEL; // see (RULE_21)
    else
      case ({ras_n, cas_n, we_n})
        3'h7: cmd = DLP_CMD_NOP; // see (RULE_21)
        3'h1: cmd = DLP_CMD_AREF; // see (RULE_01)
        3'h0: cmd = DLP_CMD_MRS;
        3'h2: cmd = DLP_CMD_PRE;
        3'h3: cmd = DLP_CMD_ACT;
        3'h4: cmd = DLP_CMD_WRITE;
        3'h5: cmd = DLP_CMD_READ;
        default: cmd = DLP_CMD_NOP;
      endcase
  end
endmodule // dlp_cmd_decode

// >>> dlp_dram_end.sv
`timescale 1ns/100ps
`include "dlp_consts.svh"
module dlp_dram_end (
  input wire logic clk,
  input wire logic sys_rst,
  dlp_if.dram link,
  input wire logic banks_open,
  output logic in_self_refresh,
  output logic in_powerdown,
  output logic active_powerdown,
  output logic dll_enabled,
  output logic buffers_enabled,
  output logic cmd_valid,
  output dlp_pkg::dlp_cmd_e cmd_out,
  output logic contents_lost
);
  import dlp_pkg::*;
  typedef struct packed {
    dlp_state_e st;
    logic cke_prev;
    logic slow_exit;
    dlp_cnt_t cnt;
    logic cmd_valid;
    dlp_cmd_e cmd;
    logic lost;
  } dlp_dram_s;
  dlp_dram_s s_reg;
  dlp_dram_s s_next;
  dlp_cmd_e dec;
  logic idle_cmd;
  dlp_cmd_decode u_dec (.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .cmd(dec));
  assign idle_cmd = (dec == DLP_CMD_NOP) || (dec == DLP_CMD_DESEL);
  always_comb
  begin
    s_next = s_reg;
    s_next.cke_prev = link.cke;
    s_next.cmd_valid = 1'b0;
    if (s_reg.cnt != '0)
      s_next.cnt = s_reg.cnt - 16'h0001;
    case (s_reg.st)
      DLP_ST_RUN:
      begin
        if (s_reg.cke_prev && !link.cke)
        begin
          if (dec == DLP_CMD_AREF && !banks_open)
            s_next.st = DLP_ST_SREF; // see (RULE_01)
          else if (idle_cmd)
          begin
            s_next.st = banks_open ? DLP_ST_APD : DLP_ST_PPD; // see (RULE_09) see (RULE_11)
            s_next.slow_exit = link.a12; // see (RULE_11)
          end
          else
            s_next.lost = 1'b1; // see (RULE_23)
        end
        else if (link.cke && !idle_cmd)
        begin
          s_next.cmd_valid = 1'b1;
          s_next.cmd = dec;
        end
      end
      DLP_ST_SREF:
      begin
        // Only CKE is looked at here; clock may be stopped
        if (link.cke)
        begin
          s_next.st = DLP_ST_SREF_EXIT; // see (RULE_03)
          s_next.cnt = 16'(`DLP_SR_EXIT_NONREAD_CYC); // see (RULE_06)
        end
      end
      DLP_ST_PPD, DLP_ST_APD:
      begin
        if (link.cke && idle_cmd)
        begin
          s_next.st = DLP_ST_PD_EXIT; // see (RULE_16)
          if (s_reg.st == DLP_ST_PPD)
            s_next.cnt = 16'(`DLP_PRECHARGE_PD_EXIT_CYC);
          else if (s_reg.slow_exit)
            s_next.cnt = 16'(`DLP_SLOW_ACTIVE_EXIT_CYC);
          else
            s_next.cnt = 16'(`DLP_FAST_ACTIVE_EXIT_CYC);
        end
      end
      DLP_ST_SREF_EXIT, DLP_ST_PD_EXIT:
      begin
        if (s_reg.cnt <= 16'h0001)
          s_next.st = DLP_ST_RUN;
      end
      default: s_next.st = DLP_ST_RUN;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg.st <= DLP_ST_RUN;
      s_reg.cke_prev <= 1'b0;
      s_reg.slow_exit <= 1'b0;
      s_reg.cnt <= '0;
      s_reg.cmd_valid <= 1'b0;
      s_reg.cmd <= DLP_CMD_NOP;
      s_reg.lost <= 1'b0;
    end
    else
      s_reg <= s_next;
  end
  assign in_self_refresh = (s_reg.st == DLP_ST_SREF);
  assign in_powerdown = (s_reg.st == DLP_ST_PPD) || (s_reg.st == DLP_ST_APD);
  assign active_powerdown = (s_reg.st == DLP_ST_APD);
  // Loop survives only fast-exit active power-down
  assign dll_enabled = !(in_self_refresh || s_reg.st == DLP_ST_PPD ||
    (s_reg.st == DLP_ST_APD && s_reg.slow_exit)); // see (RULE_12)
  assign buffers_enabled = !(in_powerdown || in_self_refresh); // see (RULE_13)
  assign cmd_valid = s_reg.cmd_valid;
  assign cmd_out = s_reg.cmd;
  assign contents_lost = s_reg.lost;
endmodule // dlp_dram_end

// >>> dlp_assertions.sv
`timescale 1ns/100ps
`include "dlp_consts.svh"
module dlp_assertions #(
  parameter int REFI_CYC = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic a12
);
  localparam int NONREAD_CYC = `DLP_SR_EXIT_NONREAD_CYC;
  logic nop;
  logic sref_cmd;
  logic cke_reg;
  logic sref_reg;
  logic [7:0] xs_reg;
  logic [15:0] pd_reg;
  assign nop = cs_n || (ras_n && cas_n && we_n);
  assign sref_cmd = !cs_n && !ras_n && !cas_n && we_n;
  // Window counter covers both the non-read and the read exit delay
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cke_reg <= 1'b1;
      sref_reg <= 1'b0;
      xs_reg <= 8'h00;
      pd_reg <= 16'h0000;
    end
    else
    begin
      cke_reg <= cke;
      if (!cke && cke_reg && sref_cmd)
        sref_reg <= 1'b1;
      else if (cke)
        sref_reg <= 1'b0;
      if (cke && sref_reg)
        xs_reg <= 8'hC7;
      else if (xs_reg != 8'h00)
        xs_reg <= xs_reg - 8'h01;
      pd_reg <= cke ? 16'h0000 : pd_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_cke_low_min: assert property ($fell(cke) |-> !cke [*3])
    else $error("clock enable low phase too short");
  a_cke_high_min: assert property ($rose(cke) |-> cke [*3])
    else $error("clock enable high phase too short");
  a_entry_cmd: assert property ($fell(cke) |-> nop || sref_cmd)
    else $error("low-power entry with a wrong command");
  a_sref_odt_off: assert property ($fell(cke) && sref_cmd |-> !odt)
    else $error("termination on at self-refresh entry");
  a_odt_relock: assert property (sref_reg || xs_reg != 8'h00 |-> !odt)
    else $error("termination on before read exit delay");
  a_exit_nop: assert property ($rose(cke) |-> nop)
    else $error("low-power exit with a wrong command");
  a_sref_exit_hold: assert property (int'(xs_reg) > 200 - NONREAD_CYC |-> cke && nop)
    else $error("exit interval broken");
  a_pd_stay_max: assert property (!sref_reg |-> int'(pd_reg) <= 9 * REFI_CYC)
    else $error("power-down stay too long");
  c_sref: cover property ($fell(cke) && sref_cmd);
  c_pd: cover property ($fell(cke) && nop);
  c_slow: cover property ($rose(cke) && a12);
endmodule // dlp_assertions

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  import dlp_pkg::*;
  typedef struct packed {
    logic sr;
    logic open;
    logic slow;
    logic [4:0] exp;
    logic [4:0] msk;
    logic [7:0] lat;
  } dlp_row_s;
  logic clk;
  logic sys_rst;
  logic rq_sr;
  logic rq_pd;
  logic rq_wk;
  logic slow;
  logic idle;
  logic busy;
  logic open;
  logic low_power;
  logic ready;
  logic read_ready;
  logic lost;
  logic bv;
  logic bl;
  logic [4:0] st;
  dlp_cmd_e bc;
  int err_total;
  int total_checks;
  dlp_row_s rows [4] = '{'{1'b0, 1'b0, 1'b0, 5'h08, 5'h1F, 8'h02}, '{1'b0, 1'b1, 1'b0, 5'h0E, 5'h1F, 8'h02},
    '{1'b0, 1'b1, 1'b1, 5'h0C, 5'h1F, 8'h08}, '{1'b1, 1'b0, 1'b0, 5'h10, 5'h1C, 8'h0E}};
  dlp_if lk();
  dlp_if lk_b();
  dlp_ctrl_end #(.REFI_CYC(10)) u_dlp_ctrl_end (.clk(clk), .sys_rst(sys_rst), .link(lk), .req_self_refresh(rq_sr),
    .req_powerdown(rq_pd), .req_wake(rq_wk), .slow_exit_sel(slow), .banks_idle(idle), .burst_busy(busy),
    .low_power(low_power), .ready(ready), .read_ready(read_ready));
  dlp_dram_end u_dlp_dram_end (.clk(clk), .sys_rst(sys_rst), .link(lk), .banks_open(open), .in_self_refresh(st[4]),
    .in_powerdown(st[3]), .active_powerdown(st[2]), .dll_enabled(st[1]), .buffers_enabled(st[0]), .cmd_valid(),
    .cmd_out(), .contents_lost(lost));
  dlp_dram_end u_dlp_dram_end_b (.clk(clk), .sys_rst(sys_rst), .link(lk_b), .banks_open(1'b0), .in_self_refresh(),
    .in_powerdown(), .active_powerdown(), .dll_enabled(), .buffers_enabled(), .cmd_valid(bv), .cmd_out(bc),
    .contents_lost(bl));
  dlp_assertions #(.REFI_CYC(10)) u_dlp_assertions (.clk(clk), .sys_rst(sys_rst), .cke(lk.cke), .cs_n(lk.cs_n),
    .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .odt(lk.odt), .a12(lk.a12));
  task automatic close_out;
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH %0t check %0d", $time, total_checks);
    end
  endtask
  task automatic wait_cke(input logic v);
    for (int n = 0; n < 50 && lk.cke !== v; n++)
      @(negedge clk);
  endtask
  // Second link: one cycle of command, then idle; counts decoded read pulses
  task automatic drive_b(input logic ck, input logic [3:0] c, output int v);
    {lk_b.cke, lk_b.cs_n, lk_b.ras_n, lk_b.cas_n, lk_b.we_n} = {ck, c};
    v = 0;
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk);
      if (i == 0)
        {lk_b.cs_n, lk_b.ras_n, lk_b.cas_n, lk_b.we_n} = 4'h7;
      v += (bv === 1'b1 && bc === DLP_CMD_READ);
    end
  endtask
  task automatic run_row(input dlp_row_s r);
    int lr;
    int lrr;
    {open, idle, slow, rq_sr, rq_pd} = {r.open, !r.open, r.slow, r.sr, !r.sr};
    wait_cke(1'b0);
    chk(r.sr ? {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} === 4'h1 : lk.cs_n | (lk.ras_n & lk.cas_n & lk.we_n));
    {rq_sr, rq_pd} = 2'h0;
    repeat (4) @(negedge clk);
    chk((st & r.msk) === (r.exp & r.msk));
    rq_wk = 1'b1;
    wait_cke(1'b1);
    rq_wk = 1'b0;
    lr = -1;
    lrr = -1;
    for (int n = 0; n < 300 && (lr < 0 || lrr < 0); n++)
    begin
      if (ready === 1'b1 && lr < 0)
        lr = n;
      if (read_ready === 1'b1 && lrr < 0)
        lrr = n;
      @(negedge clk);
    end
    chk(lr == r.lat);
    if (r.sr)
      chk(lrr == 200);
    repeat (6) @(negedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    // Margin of about sixty-five times the longest expected run
    #200000;
    err_total++;
    close_out();
  end
  initial
  begin
    int v;
    {sys_rst, rq_sr, rq_pd, rq_wk, slow, idle, busy, open} = 8'h84;
    {lk_b.cke, lk_b.cs_n, lk_b.ras_n, lk_b.cas_n, lk_b.we_n} = 5'h17;
    err_total = 0;
    total_checks = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i])
      run_row(rows[i]);
    {busy, rq_pd} = 2'h3;
    repeat (6) @(negedge clk);
    chk(lk.cke);
    busy = 1'b0;
    wait_cke(1'b0);
    chk(low_power);
    {rq_pd, sys_rst} = 2'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({lk.cke, lk.odt, low_power, st[3], lost} === 5'h10);
    {idle, rq_sr} = 2'h1;
    repeat (8) @(negedge clk);
    chk(lk.cke);
    rq_sr = 1'b0;
    drive_b(1'b1, 4'h5, v);
    chk(v == 1);
    drive_b(1'b1, 4'h7, v);
    chk(v == 0 && bl === 1'b0);
    drive_b(1'b1, 4'h8, v);
    chk(v == 0);
    drive_b(1'b0, 4'h5, v);
    chk(bl);
    close_out();
  end
endmodule // tb
